// ---- verilog/split_timer_defines.vh ----
// Purpose: constants for the split-mode dual byte timer
// Assumes: AXI4-Lite byte addresses are four times the register index
// Notes: definitions only
`ifndef SPLIT_TIMER_DEFINES_VH
`define SPLIT_TIMER_DEFINES_VH
`define IDX_ENABLE_CTRL 8'h00
`define IDX_GATE_CTRL 8'h01
`define IDX_FORCE 8'h02
`define IDX_SPLIT 8'h03
`define IDX_CMD_CLR 8'h04
`define IDX_CMD_SET 8'h05
`define IDX_IRQ_EN 8'h0A
`define IDX_IRQ_FLAG 8'h0B
`define IDX_LOW_COUNTER_VALUE 8'h20
`define IDX_HCNT 8'h21
`define IDX_LPER 8'h26
`define IDX_HPER 8'h27
`define IDX_LCMP0 8'h28
`define IDX_LCMP1 8'h2A
`define IDX_LCMP2 8'h2C
`define RST_BYTE 8'h00
`define RST_PER 8'hFF
`define CMD_NONE 2'h0
`define CMD_RESTART 2'h2
`define CMD_HARD_RESET 2'h3
`define TARGET_BOTH 2'h3
`define CMD_LO 2
`define CMD_HI 3
`define FLAG_LOW_UNDERFLOW 0
`define FLAG_HIGH_UNDERFLOW 1
`define FLAG_LCMP_LO 4
`define FLAG_MASK 8'h73
`define GATE_MASK 8'h77
`define SPLIT_MASK 8'h01
`define TARGET_MASK 8'h03
`define TARGET_NONE 2'h0
`define TGT_HI 1
`define TGT_LO 0
`define ENABLE_BIT 0
`define SPLIT_BIT 0
`define LOW_CHANNELS 3
`define COUNT_STEP 8'h01
`define WAVE_IDLE 6'h00
`define IRQ_IDLE 5'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- verilog/dual_byte_timer_split_control.v ----
// Purpose: split-mode control, flags and forced outputs of a dual 8-bit down timer
// Assumes: AXI4-Lite slave, one clock, synchronous active-low reset
// Notes: counters tick every clock; prescaler and waveform generation are outside
//    a hard reset command is refused while running, so software must stop first
//    forced levels read back even while running, but reach the pins only when stopped
`timescale 1ns/100ps
`include "split_timer_defines.vh"
module dual_byte_timer_split_control
(
   input wire aclk,
   input wire aresetn,
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg [5:0] wave_output_pin,
   output reg [5:0] wave_to_logic_unit,
   output reg [4:0] irq_request
);
   // Bus state
   reg aw_held;
   reg w_held;
   reg [7:0] aw_idx;
   reg [7:0] w_byte;
   reg w_lane;
   // Registers
   reg timer_enable;
   reg [7:0] compare_output_gate;
   reg [7:0] output_value_force;
   reg split_select_bit;
   reg [1:0] command_target;
   reg [7:0] irq_enable_bits;
   reg [7:0] irq_flag_bits;
   reg [7:0] low_counter_value;
   reg [7:0] high_counter_value;
   reg [7:0] low_period;
   reg [7:0] high_period;
   reg [7:0] low_cmp [0:2];
   wire [2:0] low_compare_event;
   reg [7:0] rd_byte;
   reg rd_ok;
   // Next-state values
   reg [7:0] next_low_count;
   reg [7:0] next_high_count;
   wire [7:0] next_irq_flags;
   // Write strobes and flag terms
   wire reg_write;
   wire split_write;
   wire [7:0] flag_clear;
   wire [7:0] flag_set;
   wire do_write;
   wire [1:0] cmd_code;
   wire cmd_both;
   wire restart_cmd;
   wire hard_reset_cmd;
   wire low_underflow;
   wire high_underflow;
   wire [2:0] low_force_level;
   wire [2:0] high_force_level;
   wire [5:0] force_level;
   wire [5:0] gate_bits;
   integer i;
   genvar ch;

   // Register index from a byte address; addresses above 0x3FF fall outside the map, low two address bits are ignored
   function [7:0] reg_index;
      input [31:0] addr;
      begin
         reg_index = (addr[31:10] == 22'h000000) ? addr[9:2] : 8'hFF;
      end
   endfunction

   // Split-layout registers are decoded only while split mode is on; the rest always are
   function mapped;
      input [7:0] idx;
      input split_on;
      begin
         case (idx)
            `IDX_ENABLE_CTRL, `IDX_GATE_CTRL, `IDX_FORCE, `IDX_SPLIT,
            `IDX_CMD_CLR, `IDX_CMD_SET, `IDX_IRQ_EN, `IDX_IRQ_FLAG:
               mapped = 1'b1;
            `IDX_LOW_COUNTER_VALUE, `IDX_HCNT, `IDX_LPER, `IDX_HPER,
            `IDX_LCMP0, `IDX_LCMP1, `IDX_LCMP2:
               mapped = split_on;
            default:
               mapped = 1'b0;
         endcase
      end
   endfunction

   assign do_write = aw_held & w_held & ~s_axi_bvalid;
   // Byte lane 0 carries every register; the split-only ones need split mode too
   assign reg_write = do_write & w_lane;
   assign split_write = reg_write & split_select_bit;

   // Command decode happens at the write itself; the field never stores
   assign cmd_code = w_byte[`CMD_HI:`CMD_LO];
   assign cmd_both = (w_byte[`TGT_HI:`TGT_LO] == `TARGET_BOTH) |
                     (command_target == `TARGET_BOTH);
   assign restart_cmd = do_write & w_lane & split_select_bit & cmd_both &
                        (aw_idx == `IDX_CMD_SET) & (cmd_code == `CMD_RESTART);
   assign hard_reset_cmd = do_write & w_lane & split_select_bit & cmd_both & ~timer_enable &
                           (aw_idx == `IDX_CMD_SET) & (cmd_code == `CMD_HARD_RESET);

   // Down counters reach bottom when at zero and counting
   assign low_underflow = timer_enable & split_select_bit & (low_counter_value == `RST_BYTE);
   assign high_underflow = timer_enable & split_select_bit & (high_counter_value == `RST_BYTE);

   assign low_force_level = output_value_force[2:0];
   assign high_force_level = output_value_force[6:4];
   assign force_level = {high_force_level, low_force_level};
   assign gate_bits = {compare_output_gate[6:4], compare_output_gate[2:0]};

   // Compare matches per low channel; a stopped counter sitting on a match keeps setting it
   generate
      for (ch = 0; ch < `LOW_CHANNELS; ch = ch + 1)
      begin : g_low_cmp
         assign low_compare_event[ch] = split_select_bit &
                                        (low_counter_value == low_cmp[ch]);
      end
   endgenerate

   // Write channel capture; address and data may arrive in either order
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_idx <= `RST_BYTE;
         w_byte <= `RST_BYTE;
         w_lane <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~w_held & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_idx <= reg_index(s_axi_awaddr);
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane <= s_axi_wstrb[0];
         end
         if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_idx, split_select_bit) ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (s_axi_bvalid & s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
      end
   end

   // Hardware sets win over a software clear in the same cycle
   assign flag_clear = (reg_write & (aw_idx == `IDX_IRQ_FLAG)) ? w_byte : `RST_BYTE;
   assign flag_set = {1'b0, low_compare_event, 2'b00,
                      high_underflow, low_underflow};
   // A hard reset clears every flag and wins over any event in its cycle
   assign next_irq_flags = hard_reset_cmd ? `RST_BYTE :
                           ((irq_flag_bits & ~flag_clear) | flag_set);

   // Next counter values: restart and hard reset clear, counting reloads at bottom
   always @*
   begin
      next_low_count = low_counter_value;
      next_high_count = high_counter_value;
      if (hard_reset_cmd | restart_cmd)
      begin
         next_low_count = `RST_BYTE;
         next_high_count = `RST_BYTE;
      end
      else if (timer_enable & split_select_bit)
      begin
         next_low_count = low_underflow ? low_period : low_counter_value - `COUNT_STEP;
         next_high_count = high_underflow ? high_period : high_counter_value - `COUNT_STEP;
      end
      // A bus write to a counter beats count, clear and reload in the same cycle
      if (split_write & (aw_idx == `IDX_LOW_COUNTER_VALUE))
         next_low_count = w_byte;
      if (split_write & (aw_idx == `IDX_HCNT))
         next_high_count = w_byte;
   end

   // Control registers; a hard reset clears the target even though it was just written
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         timer_enable <= 1'b0;
         compare_output_gate <= `RST_BYTE;
         output_value_force <= `RST_BYTE;
         split_select_bit <= 1'b0;
         command_target <= `TARGET_NONE;
         irq_enable_bits <= `RST_BYTE;
      end
      else if (hard_reset_cmd)
         command_target <= `TARGET_NONE;
      else if (reg_write)
      begin
         case (aw_idx)
            `IDX_ENABLE_CTRL: timer_enable <= w_byte[`ENABLE_BIT];
            `IDX_GATE_CTRL: compare_output_gate <= w_byte & `GATE_MASK;
            `IDX_FORCE: output_value_force <= w_byte & `GATE_MASK;
            `IDX_SPLIT: split_select_bit <= w_byte[`SPLIT_BIT];
            `IDX_CMD_CLR: command_target <= command_target & ~w_byte[`TGT_HI:`TGT_LO];
            `IDX_CMD_SET: command_target <= command_target | w_byte[`TGT_HI:`TGT_LO];
            `IDX_IRQ_EN: irq_enable_bits <= w_byte & `FLAG_MASK;
            default: ;
         endcase
      end
   end

   // Counters, periods and compares; periods reset to the top value
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         low_counter_value <= `RST_BYTE;
         high_counter_value <= `RST_BYTE;
         low_period <= `RST_PER;
         high_period <= `RST_PER;
         for (i = 0; i < `LOW_CHANNELS; i = i + 1)
            low_cmp[i] <= `RST_BYTE;
      end
      else
      begin
         low_counter_value <= next_low_count;
         high_counter_value <= next_high_count;
         // Split-only registers ignore writes in the normal layout
         if (split_write)
         begin
            case (aw_idx)
               `IDX_LPER: low_period <= w_byte;
               `IDX_HPER: high_period <= w_byte;
               `IDX_LCMP0: low_cmp[0] <= w_byte;
               `IDX_LCMP1: low_cmp[1] <= w_byte;
               `IDX_LCMP2: low_cmp[2] <= w_byte;
               default: ;
            endcase
         end
      end
   end

   // Sticky interrupt flags
   always @(posedge aclk)
   begin
      if (!aresetn)
         irq_flag_bits <= `RST_BYTE;
      else
         irq_flag_bits <= next_irq_flags;
   end

   // Read data mux
   always @*
   begin
      rd_ok = mapped(reg_index(s_axi_araddr), split_select_bit);
      case (reg_index(s_axi_araddr))
         `IDX_ENABLE_CTRL: rd_byte = {7'h00, timer_enable};
         `IDX_GATE_CTRL: rd_byte = compare_output_gate;
         `IDX_FORCE: rd_byte = output_value_force;
         `IDX_SPLIT: rd_byte = {7'h00, split_select_bit};
         `IDX_CMD_CLR, `IDX_CMD_SET: rd_byte = {6'h00, command_target};
         `IDX_IRQ_EN: rd_byte = irq_enable_bits;
         `IDX_IRQ_FLAG: rd_byte = irq_flag_bits;
         `IDX_LOW_COUNTER_VALUE: rd_byte = low_counter_value;
         `IDX_HCNT: rd_byte = high_counter_value;
         `IDX_LPER: rd_byte = low_period;
         `IDX_HPER: rd_byte = high_period;
         `IDX_LCMP0: rd_byte = low_cmp[0];
         `IDX_LCMP1: rd_byte = low_cmp[1];
         `IDX_LCMP2: rd_byte = low_cmp[2];
         default: rd_byte = `RST_BYTE;
      endcase
      if (!rd_ok)
         rd_byte = `RST_BYTE;
   end

   // Read channel: one-cycle accept then data
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid & s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (s_axi_rvalid & s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Pin and logic-unit levels; while running the forced level stays held low here
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wave_output_pin <= `WAVE_IDLE;
         wave_to_logic_unit <= `WAVE_IDLE;
      end
      else if (timer_enable)
      begin
         // Waveform generation sits outside; nothing forced reaches the pins meanwhile
         wave_output_pin <= `WAVE_IDLE;
         wave_to_logic_unit <= `WAVE_IDLE;
      end
      else
      begin
         wave_output_pin <= force_level & gate_bits;
         wave_to_logic_unit <= force_level;
      end
   end

   // Interrupt requests are registered so the lines never glitch
   always @(posedge aclk)
   begin
      if (!aresetn)
         irq_request <= `IRQ_IDLE;
      else
         irq_request <= {irq_flag_bits[6:4], irq_flag_bits[1:0]} &
                        {irq_enable_bits[6:4], irq_enable_bits[1:0]};
   end
endmodule

// ---- tb/split_timer_monitor.sv ----
// Purpose: port-level checks for the split-mode dual byte timer control block
// Assumes: one clock, synchronous active-low reset, bus answers within a few cycles
// Notes: register state is unseen here, so effects are tied to the last bus write
`timescale 1ns/100ps
`include "split_timer_defines.vh"
module split_timer_monitor
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic [5:0] wave_output_pin,
   input wire logic [5:0] wave_to_logic_unit,
   input wire logic [4:0] irq_request
);
   logic [3:0] since_wr;
   logic [7:0] rd_idx;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Cycles since the last data handshake; saturates so it never wraps
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         since_wr <= 4'hF;
         rd_idx <= 8'h00;
      end
      else
      begin
         if (s_axi_wvalid && s_axi_wready)
            since_wr <= 4'h0;
         else if (since_wr != 4'hF)
            since_wr <= since_wr + 4'h1;
         if (s_axi_arvalid && s_axi_arready)
            rd_idx <= s_axi_araddr[9:2];
      end
   end

   sequence wr_taken;
      s_axi_wvalid && s_axi_wready;
   endsequence
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("write address ready held longer than one cycle");
   a_write_answer: assert property (wr_taken |-> ##[1:4] s_axi_bvalid)
      else $error("write response missing after data handshake");
   a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response stayed after handshake");
   a_read_answer: assert property (ar_taken |-> ##1 s_axi_rvalid)
      else $error("read data not one cycle after address handshake");
   a_err_data_zero: assert property (
      s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h00000000)
      else $error("refused read returned data");
   a_pad_needs_logic: assert property (
      (wave_output_pin & ~wave_to_logic_unit) == 6'h00)
      else $error("pad level high without the ungated level");
   a_pins_after_write: assert property (
      $changed(wave_to_logic_unit) |-> since_wr <= 4'h6)
      else $error("forced level moved without a register write");
   a_irq_after_write: assert property (
      ($past(irq_request) & ~irq_request) != 5'h00 |-> since_wr <= 4'h6)
      else $error("interrupt request dropped without a register write");
   a_cmd_reads_zero: assert property (
      s_axi_rvalid && (rd_idx == `IDX_CMD_CLR || rd_idx == `IDX_CMD_SET)
      |-> s_axi_rdata[3:2] == 2'h0)
      else $error("command field read back nonzero");
endmodule

// ---- tb/dual_byte_timer_split_control_tb_top.sv ----
// Purpose: self-checking bench for the split-mode dual byte timer control block
// Assumes: byte address is four times the register index
// Notes: outputs are compared two cycles after the write response
`timescale 1ns/100ps
`include "split_timer_defines.vh"
module dual_byte_timer_split_control_tb_top;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_data;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [5:0] wave_output_pin, wave_to_logic_unit;
   logic [4:0] irq_request;
   int failures, compares;

   dual_byte_timer_split_control dut_u
   (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wave_output_pin, .wave_to_logic_unit,
      .irq_request
   );

   // Bus clock
   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic a, w;
      a = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= {22'h000000, idx, 2'b00};
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(a && w))
      begin
         @(posedge aclk);
         if (s_axi_awready)
         begin
            a = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready)
         begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rc(input string name, input logic [7:0] idx, input logic [31:0] exp,
                     input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= {22'h000000, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      rd_data = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      chk(name, rd_data, exp);
      chk(name, {30'h00000000, resp}, {30'h00000000, er});
   endtask

   task automatic settle;
      repeat (2) @(posedge aclk);
   endtask

   task automatic stop_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Watchdog; the whole sequence needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge aclk);
      failures++;
      stop_test();
   end

   // Main sequence
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      s_axi_wstrb = 4'hF;
      aresetn = 1'b0;
      failures = 0;
      compares = 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rc("split", `IDX_SPLIT, 32'h0, `RESP_OKAY);
      rc("irq enable", `IDX_IRQ_EN, 32'h0, `RESP_OKAY);
      rc("flags", `IDX_IRQ_FLAG, 32'h0, `RESP_OKAY);
      rc("gap", 8'h06, 32'h0, `RESP_SLVERR);
      rc("low count", `IDX_LOW_COUNTER_VALUE, 32'h0, `RESP_SLVERR);
      $display("test reset done");
      wr(`IDX_FORCE, 8'h52);
      settle();
      chk("logic", wave_to_logic_unit, 32'h2A);
      chk("pad", wave_output_pin, 32'h00);
      wr(`IDX_GATE_CTRL, 8'h07);
      settle();
      chk("pad low", wave_output_pin, 32'h02);
      wr(`IDX_GATE_CTRL, 8'h77);
      settle();
      chk("pad all", wave_output_pin, 32'h2A);
      $display("test force done");
      wr(`IDX_SPLIT, 8'h01);
      rc("split", `IDX_SPLIT, 32'h1, `RESP_OKAY);
      rc("low count", `IDX_LOW_COUNTER_VALUE, 32'h0, `RESP_OKAY);
      wr(`IDX_CMD_SET, 8'h03);
      rc("cmd set", `IDX_CMD_SET, 32'h3, `RESP_OKAY);
      wr(`IDX_CMD_CLR, 8'h01);
      rc("cmd clr", `IDX_CMD_CLR, 32'h2, `RESP_OKAY);
      wr(`IDX_CMD_SET, 8'h04);
      rc("cmd code", `IDX_CMD_SET, 32'h2, `RESP_OKAY);
      $display("test command registers done");
      wr(`IDX_CMD_CLR, 8'h03);
      wr(`IDX_LOW_COUNTER_VALUE, 8'h05);
      wr(`IDX_HCNT, 8'h02);
      wr(`IDX_LCMP0, 8'h03);
      wr(`IDX_LCMP1, 8'h80);
      wr(`IDX_LCMP2, 8'h40);
      wr(`IDX_IRQ_FLAG, 8'h73);
      wr(`IDX_IRQ_EN, 8'h11);
      rc("flags clear", `IDX_IRQ_FLAG, 32'h0, `RESP_OKAY);
      wr(`IDX_ENABLE_CTRL, 8'h01);
      repeat (20) @(posedge aclk);
      wr(`IDX_ENABLE_CTRL, 8'h00);
      rc("flags set", `IDX_IRQ_FLAG, 32'h13, `RESP_OKAY);
      chk("irq", irq_request, 32'h05);
      wr(`IDX_IRQ_FLAG, 8'h01);
      rc("flags w1c", `IDX_IRQ_FLAG, 32'h12, `RESP_OKAY);
      wr(`IDX_IRQ_EN, 8'h72);
      settle();
      chk("irq high", irq_request, 32'h06);
      $display("test flags done");
      wr(`IDX_ENABLE_CTRL, 8'h01);
      wr(`IDX_CMD_SET, 8'h0F);
      wr(`IDX_LOW_COUNTER_VALUE, 8'h50);
      rc("count write", `IDX_LOW_COUNTER_VALUE, 32'h4D, `RESP_OKAY);
      wr(`IDX_ENABLE_CTRL, 8'h00);
      rc("flags kept", `IDX_IRQ_FLAG, 32'h12, `RESP_OKAY);
      wr(`IDX_CMD_SET, 8'h0F);
      rc("flags hard", `IDX_IRQ_FLAG, 32'h0, `RESP_OKAY);
      rc("target", `IDX_CMD_SET, 32'h0, `RESP_OKAY);
      wr(`IDX_LOW_COUNTER_VALUE, 8'h07);
      wr(`IDX_CMD_SET, 8'h08);
      rc("count kept", `IDX_LOW_COUNTER_VALUE, 32'h7, `RESP_OKAY);
      wr(`IDX_CMD_SET, 8'h0B);
      rc("count zero", `IDX_LOW_COUNTER_VALUE, 32'h0, `RESP_OKAY);
      wr(8'h06, 8'hFF);
      chk("bad write", {30'h00000000, resp}, {30'h00000000, `RESP_SLVERR});
      $display("test commands done");
      stop_test();
   end
endmodule

bind dual_byte_timer_split_control split_timer_monitor mon_u
(
   .aclk, .aresetn, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .wave_output_pin, .wave_to_logic_unit, .irq_request
);
